// ---- logic/tcp_control.sv ----
// Host control of the timer coprocessor: timebases, stop, emulation, channels
`timescale 1ns/1ns
module tcp_control (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ext_timebase_pin,
  input tcp_pkg::tcp_host_req_t host_req,
  output tcp_pkg::tcp_host_rsp_t host_rsp,
  input wire logic [2:0] channel_irq_level,
  input wire logic [15:0] chan_flag_set,
  input wire logic [15:0] service_done,
  input wire logic [3:0] view_chan,
  output tcp_pkg::tcp_chan_view_t chan_view,
  input wire logic emu_ram_req,
  output logic emu_ram_grant,
  output logic emulation_enable,
  output logic engine_run,
  output logic stopped_flag,
  output logic [15:0] irq_req,
  output logic [15:0] first_timebase,
  output logic [15:0] second_timebase
);
  import tcp_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] mcr_reg;
  logic emu_written_reg;
  logic [15:0] irq_en_reg;
  logic [15:0] flag_reg;
  logic [15:0] flag_next;
  logic [15:0] armed_reg;
  logic [63:0] func_reg;
  logic [31:0] seq_reg;
  logic [31:0] srv_reg;
  logic [31:0] srv_next;
  logic [4:0] div_reg;
  logic pin_meta, pin_sync, pin_filt, pin_filt_d;
  logic [1:0] filt_sh;
  logic is_word, is_flag, wr_ok, stop_on;
  logic [15:0] lane_mask, rd_word;
  logic tick_first, tick_second, sysclk_over_eight;

  assign is_word = host_req.be == 2'b11;
  assign is_flag = host_req.addr[8:1] == OFS_IRQ_FLAG[8:1];
  assign lane_mask = {{8{host_req.be[1]}}, {8{host_req.be[0]}}};
  // Byte lanes only count for the flag word; others must be whole words
  assign wr_ok = host_req.wr && (is_word || is_flag);
  assign stop_on = mcr_reg[MCR_STOP];

  // ----------------------------------------------------------------------
  // Configuration word
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mcr_reg <= MCR_RESET;
      emu_written_reg <= 1'b0;
    end else if (wr_ok && host_req.addr[8:1] == OFS_MODULE_CONFIG[8:1]) begin
      mcr_reg[MCR_STOP] <= host_req.wdata[MCR_STOP];
      mcr_reg[MCR_FB_DIV +: 2] <= host_req.wdata[MCR_FB_DIV +: 2];
      mcr_reg[MCR_SB_DIV +: 2] <= host_req.wdata[MCR_SB_DIV +: 2];
      mcr_reg[MCR_CLK_GATE] <= host_req.wdata[MCR_CLK_GATE];
      mcr_reg[MCR_PRESCALER_SOURCE_SELECT] <= host_req.wdata[MCR_PRESCALER_SOURCE_SELECT];
      // First write fixes the mode until the next reset
      if (!emu_written_reg) begin
        mcr_reg[MCR_EMU] <= host_req.wdata[MCR_EMU];
        emu_written_reg <= 1'b1;
      end
    end
  end

  // Flag follows the stop bit once the counters have frozen
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stopped_flag <= 1'b0;
    end else begin
      stopped_flag <= stop_on;
    end
  end

  assign emulation_enable = mcr_reg[MCR_EMU];
  assign emu_ram_grant = emu_ram_req && !mcr_reg[MCR_EMU];
  assign engine_run = !stop_on;

  // ----------------------------------------------------------------------
  // System clock divider and pin conditioning
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg <= 5'h00;
    end else if (!stop_on) begin
      div_reg <= 5'(div_reg + 5'h01);
    end
  end

  assign tick_first = mcr_reg[MCR_PRESCALER_SOURCE_SELECT] ? (div_reg[1:0] == DIV_LAST_4)
                                        : (div_reg == DIV_LAST_32);
  assign sysclk_over_eight = div_reg[2:0] == DIV_LAST_8;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= ext_timebase_pin;
      pin_sync <= pin_meta;
    end
  end

  // Three equal samples needed; glitches under 3 clocks are dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filt_sh <= 2'b00;
      pin_filt <= 1'b0;
      pin_filt_d <= 1'b0;
    end else begin
      filt_sh <= {filt_sh[0], pin_sync};
      if (pin_sync == filt_sh[0] && pin_sync == filt_sh[1]) begin
        pin_filt <= pin_sync;
      end
      pin_filt_d <= pin_filt;
    end
  end

  assign tick_second = mcr_reg[MCR_CLK_GATE]
                       ? (sysclk_over_eight && pin_sync)
                       : (pin_filt && !pin_filt_d);

  // ----------------------------------------------------------------------
  // Timebases
  // ----------------------------------------------------------------------
  tcp_timebase u_first (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_in(tick_first),
    .div_sel(mcr_reg[MCR_FB_DIV +: 2]),
    .hold(stop_on),
    .count(first_timebase)
  );

  tcp_timebase u_second (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_in(tick_second),
    .div_sel(mcr_reg[MCR_SB_DIV +: 2]),
    .hold(stop_on),
    .count(second_timebase)
  );

  // ----------------------------------------------------------------------
  // Channel interrupt enable and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_en_reg <= 16'h0000;
    end else if (wr_ok && host_req.addr[8:1] == OFS_IRQ_ENABLE[8:1]) begin
      irq_en_reg <= host_req.wdata;
    end
  end

  always_comb begin
    flag_next = flag_reg;
    if (wr_ok && is_flag) begin
      // Only bits seen set by a read and written zero are cleared
      flag_next = flag_reg & ~(armed_reg & lane_mask & ~host_req.wdata);
    end
    // A new event in the clearing cycle survives
    flag_next = flag_next | chan_flag_set;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_reg <= 16'h0000;
      armed_reg <= 16'h0000;
    end else begin
      flag_reg <= flag_next;
      if (host_req.rd && is_flag) begin
        armed_reg <= armed_reg | (flag_reg & lane_mask);
      end else if (wr_ok && is_flag) begin
        armed_reg <= armed_reg & ~lane_mask;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_req <= 16'h0000;
    end else begin
      irq_req <= flag_reg & irq_en_reg
                 & {16{channel_irq_level != 3'b000}};
    end
  end

  // ----------------------------------------------------------------------
  // Function select, sequence and service request fields
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      func_reg <= 64'h0;
      seq_reg <= 32'h0;
    end else if (wr_ok) begin
      for (int w = 0; w < 4; w++) begin
        if (host_req.addr[8:1] == 8'(OFS_FUNC0[8:1] + w)) begin
          func_reg[16*w +: 16] <= host_req.wdata;
        end
      end
      for (int w = 0; w < 2; w++) begin
        if (host_req.addr[8:1] == 8'(OFS_SEQ0[8:1] + w)) begin
          seq_reg[16*w +: 16] <= host_req.wdata;
        end
      end
    end
  end

  // Host is expected to poll for zero; a write meeting a done wins
  always_comb begin
    srv_next = srv_reg;
    for (int c = 0; c < TCP_CHANS; c++) begin
      if (service_done[c]) begin
        srv_next[2*c +: 2] = 2'b00;
      end
    end
    for (int w = 0; w < 2; w++) begin
      if (wr_ok && host_req.addr[8:1] == 8'(OFS_SRV0[8:1] + w)) begin
        srv_next[16*w +: 16] = host_req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      srv_reg <= 32'h0;
    end else begin
      srv_reg <= srv_next;
    end
  end

  // ----------------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    unique case (host_req.addr[8:1])
      OFS_MODULE_CONFIG[8:1]: begin
        rd_word = mcr_reg;
        rd_word[MCR_STOPPED] = stopped_flag;
      end
      OFS_IRQ_ENABLE[8:1]: rd_word = irq_en_reg;
      OFS_IRQ_FLAG[8:1]: rd_word = flag_reg & lane_mask;
      8'(OFS_FUNC0[8:1] + 0): rd_word = func_reg[15:0];
      8'(OFS_FUNC0[8:1] + 1): rd_word = func_reg[31:16];
      8'(OFS_FUNC0[8:1] + 2): rd_word = func_reg[47:32];
      8'(OFS_FUNC0[8:1] + 3): rd_word = func_reg[63:48];
      8'(OFS_SEQ0[8:1] + 0): rd_word = seq_reg[15:0];
      8'(OFS_SEQ0[8:1] + 1): rd_word = seq_reg[31:16];
      8'(OFS_SRV0[8:1] + 0): rd_word = srv_reg[15:0];
      8'(OFS_SRV0[8:1] + 1): rd_word = srv_reg[31:16];
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_rsp <= '0;
    end else begin
      host_rsp.ack <= host_req.rd || host_req.wr;
      // Partial access to a word-only register is refused, nothing stored
      host_rsp.err <= (host_req.rd || host_req.wr)
                      && !is_word && !is_flag;
      if (host_req.rd && (is_word || is_flag)) begin
        host_rsp.rdata <= rd_word;
      end else begin
        host_rsp.rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel request and mode decode for the microengine
  // ----------------------------------------------------------------------
  function automatic tcp_action_t act_of(logic [3:0] f, logic [1:0] r,
                                         logic [1:0] s);
    tcp_action_t a;
    a = ACT_UNIMPL;
    if (r == 2'b00) begin
      a = ACT_NONE;
    end else begin
      unique case (f)
        FN_DISCRETE_IO: a = (r == 2'd1) ? ACT_FORCE_HIGH :
                            (r == 2'd2) ? ACT_FORCE_LOW :
                            (s == 2'd2) ? ACT_UPDATE : ACT_INIT;
        FN_CAPTURE_COUNT, FN_EDGE_PERIOD:
          a = (r == 2'd1) ? ACT_INIT : ACT_UNIMPL;
        FN_OUTPUT_COMPARE: a = (r == 2'd1) ? ACT_HOST_PULSE :
                               (r == 2'd3) ? ACT_CONT_PULSE : ACT_UNIMPL;
        FN_PWM: a = (r == 2'd1) ? ACT_IMMEDIATE :
                    (r == 2'd2) ? ACT_INIT : ACT_UNIMPL;
        FN_STEPPER: a = (r == 2'd2) ? ACT_INIT :
                        (r == 2'd3) ? ACT_STEP : ACT_NONE;
        FN_SYNCED_PWM: a = (r == 2'd2) ? ACT_INIT :
                           (r == 2'd3) ? ACT_IMMEDIATE : ACT_UNIMPL;
        FN_POSITION_PULSE: a = (r == 2'd1) ? ACT_IMMEDIATE :
                               (r == 2'd2) ? ACT_INIT : ACT_FORCE_CHANGE;
        default: a = ACT_UNIMPL;
      endcase
    end
    return a;
  endfunction

  function automatic tcp_mode_t mode_of(logic [3:0] f, logic [1:0] s);
    tcp_mode_t m;
    m = MODE_NONE;
    unique case (f)
      FN_DISCRETE_IO: m = (s == 2'd0) ? MODE_TRANS : (s == 2'd1) ? MODE_MATCH
                        : (s == 2'd2) ? MODE_ON_REQUEST : MODE_UNIMPL;
      FN_CAPTURE_COUNT: m = tcp_mode_t'(5'(MODE_NOLINK_SINGLE) + 5'(s));
      FN_OUTPUT_COMPARE: m = s[1] ? MODE_TB_ONLY : MODE_EXEC_ALL;
      FN_PWM, FN_STEPPER: m = MODE_NONE;
      FN_SYNCED_PWM: m = (s == 2'd3) ? MODE_UNIMPL
                         : tcp_mode_t'(5'(MODE_0) + 5'(s));
      FN_EDGE_PERIOD: m = tcp_mode_t'(5'(MODE_EXTRA_BANK) + 5'(s));
      FN_POSITION_PULSE: m = s[0] ? MODE_BY_TIME : MODE_BY_ANGLE;
      default: m = MODE_NONE;
    endcase
    return m;
  endfunction

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_view <= '0;
    end else begin
      chan_view.func <= func_reg[4*view_chan +: 4];
      chan_view.seq <= seq_reg[2*view_chan +: 2];
      chan_view.srv <= srv_reg[2*view_chan +: 2];
      chan_view.action <= act_of(func_reg[4*view_chan +: 4],
                                 srv_reg[2*view_chan +: 2],
                                 seq_reg[2*view_chan +: 2]);
      chan_view.mode <= mode_of(func_reg[4*view_chan +: 4],
                                seq_reg[2*view_chan +: 2]);
    end
  end
endmodule

// ---- logic/tcp_pkg.sv ----
// Package: constants, field layout and types of the timer coprocessor control
package tcp_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int TCP_CHANS = 16;
  localparam int TCP_CNT_W = 16;
  localparam int TCP_ADDR_W = 9;
  // ----------------------------------------------------------------------
  // Byte offsets of the host-visible words in the 512-byte space
  // ----------------------------------------------------------------------
  localparam logic [8:0] OFS_MODULE_CONFIG = 9'h000;
  localparam logic [8:0] OFS_IRQ_ENABLE = 9'h00A;
  localparam logic [8:0] OFS_FUNC0 = 9'h00C;
  localparam logic [8:0] OFS_SEQ0 = 9'h014;
  localparam logic [8:0] OFS_SRV0 = 9'h018;
  localparam logic [8:0] OFS_IRQ_FLAG = 9'h020;
  // ----------------------------------------------------------------------
  // Module configuration word fields
  // ----------------------------------------------------------------------
  localparam int MCR_STOP = 15;
  localparam int MCR_FB_DIV = 13;
  localparam int MCR_SB_DIV = 11;
  localparam int MCR_EMU = 10;
  localparam int MCR_CLK_GATE = 9;
  localparam int MCR_STOPPED = 8;
  localparam int MCR_PRESCALER_SOURCE_SELECT = 6;
  localparam logic [15:0] MCR_RESET = 16'h0000;
  // ----------------------------------------------------------------------
  // System clock divider taps
  // ----------------------------------------------------------------------
  localparam logic [4:0] DIV_LAST_32 = 5'h1F;
  localparam logic [1:0] DIV_LAST_4 = 2'h3;
  localparam logic [2:0] DIV_LAST_8 = 3'h7;
  // ----------------------------------------------------------------------
  // Predefined time function codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] FN_SYNCED_PWM = 4'h7;
  localparam logic [3:0] FN_DISCRETE_IO = 4'h8;
  localparam logic [3:0] FN_PWM = 4'h9;
  localparam logic [3:0] FN_CAPTURE_COUNT = 4'hA;
  localparam logic [3:0] FN_EDGE_PERIOD = 4'hB;
  localparam logic [3:0] FN_POSITION_PULSE = 4'hC;
  localparam logic [3:0] FN_STEPPER = 4'hD;
  localparam logic [3:0] FN_OUTPUT_COMPARE = 4'hE;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ACT_NONE, ACT_FORCE_HIGH, ACT_FORCE_LOW, ACT_INIT, ACT_UPDATE,
    ACT_IMMEDIATE, ACT_STEP, ACT_HOST_PULSE, ACT_CONT_PULSE,
    ACT_FORCE_CHANGE, ACT_UNIMPL
  } tcp_action_t;
  typedef enum logic [4:0] {
    MODE_NONE, MODE_TRANS, MODE_MATCH, MODE_ON_REQUEST,
    MODE_NOLINK_SINGLE, MODE_NOLINK_CONT, MODE_LINK_SINGLE, MODE_LINK_CONT,
    MODE_EXEC_ALL, MODE_TB_ONLY, MODE_0, MODE_1, MODE_2,
    MODE_EXTRA_BANK, MODE_EXTRA_COUNT, MODE_MISS_BANK, MODE_MISS_COUNT,
    MODE_BY_ANGLE, MODE_BY_TIME, MODE_UNIMPL
  } tcp_mode_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } tcp_host_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } tcp_host_rsp_t;
  typedef struct packed {
    logic [3:0] func;
    logic [1:0] seq;
    logic [1:0] srv;
    tcp_action_t action;
    tcp_mode_t mode;
  } tcp_chan_view_t;
endpackage

// ---- logic/tcp_timebase.sv ----
// Prescaled timebase counter shared by both timebases
`timescale 1ns/1ns
module tcp_timebase (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick_in,
  input wire logic [1:0] div_sel,
  input wire logic hold,
  output logic [15:0] count
);
  import tcp_pkg::*;

  logic [2:0] pre_reg;
  logic [2:0] pre_last;

  // 1, 2, 4 or 8 input ticks per count
  assign pre_last = 3'((4'h1 << div_sel) - 4'h1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_reg <= 3'h0;
      count <= 16'h0000;
    end else if (tick_in && !hold) begin
      if (pre_reg >= pre_last) begin
        pre_reg <= 3'h0;
        // Natural wrap from all ones to zero
        count <= 16'(count + 16'h0001);
      end else begin
        pre_reg <= 3'(pre_reg + 3'h1);
      end
    end
  end
endmodule

// ---- bench/tcp_control_checker.sv ----
// Assertion checker for the timer coprocessor host control
`timescale 1ns/1ns
module tcp_control_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input tcp_pkg::tcp_host_req_t host_req,
  input tcp_pkg::tcp_host_rsp_t host_rsp,
  input wire logic [2:0] channel_irq_level,
  input wire logic emu_ram_req,
  input wire logic emu_ram_grant,
  input wire logic emulation_enable,
  input wire logic engine_run,
  input wire logic stopped_flag,
  input wire logic [15:0] irq_req,
  input wire logic [15:0] first_timebase,
  input wire logic [15:0] second_timebase
);
  import tcp_pkg::*;
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ack;
    host_req.rd || host_req.wr |=> host_rsp.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_err;
    host_req.wr && host_req.be != 2'h3
      && host_req.addr[8:1] != OFS_IRQ_FLAG[8:1]
      |=> host_rsp.err;
  endproperty
  a_err: assert property (p_err) else $error("partial write accepted");
  property p_unmapped;
    host_req.rd && host_req.addr >= 9'h022 |=> host_rsp.rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unused nonzero");
  property p_irq_off;
    channel_irq_level == 3'h0 |=> irq_req == 16'h0000;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request at level 0");
  property p_stopped;
    1'b1 |=> stopped_flag == !$past(engine_run);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped flag wrong");
  property p_hold;
    !engine_run |=> $stable(first_timebase) && $stable(second_timebase);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved in stop");
  property p_grant;
    emu_ram_grant == (emu_ram_req && !emulation_enable);
  endproperty
  a_grant: assert property (p_grant) else $error("ram grant wrong");
  property p_emu;
    $changed(emulation_enable) |=> $stable(emulation_enable) [*8];
  endproperty
  a_emu: assert property (p_emu) else $error("emulation bit rewritten");
  property p_step;
    $changed(first_timebase)
      |-> first_timebase == $past(first_timebase) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("first count jumped");
  property p_space;
    $changed(first_timebase) |=> $stable(first_timebase) [*3];
  endproperty
  a_space: assert property (p_space) else $error("first count too fast");
  c_stop: cover property (stopped_flag);
  c_err: cover property (host_rsp.err);
  c_irq: cover property (irq_req != 16'h0000);
endmodule
bind tcp_control tcp_control_checker u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .host_req(host_req),
  .host_rsp(host_rsp),
  .channel_irq_level(channel_irq_level),
  .emu_ram_req(emu_ram_req),
  .emu_ram_grant(emu_ram_grant),
  .emulation_enable(emulation_enable),
  .engine_run(engine_run),
  .stopped_flag(stopped_flag),
  .irq_req(irq_req),
  .first_timebase(first_timebase),
  .second_timebase(second_timebase)
);

// ---- bench/tcp_host_model.sv ----
// Host processor model on the module bus port
`timescale 1ns/1ns
module tcp_host_model (
  input wire logic clk_sys,
  output tcp_pkg::tcp_host_req_t host_req,
  input tcp_pkg::tcp_host_rsp_t host_rsp
);
  import tcp_pkg::*;
  initial host_req = '0;
  // ----------------------------------------------------------------------
  // One transfer: single-cycle strobe, answer one cycle later
  // ----------------------------------------------------------------------
  task automatic xfer(input logic rd, input logic [8:0] a,
      input logic [1:0] be, input logic [15:0] d, output tcp_host_rsp_t r);
    @(posedge clk_sys);
    host_req <= '{rd: rd, wr: !rd, addr: a, be: be, wdata: d};
    @(posedge clk_sys);
    host_req.rd <= 1'b0;
    host_req.wr <= 1'b0;
    // Released lines show the inverse so a stale value cannot pass
    host_req.addr <= ~a;
    host_req.wdata <= ~d;
    @(negedge clk_sys);
    r = host_rsp;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the timer coprocessor host control
`timescale 1ns/1ns
module tb_top;
  import tcp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ext_timebase_pin = 1'b0;
  logic [2:0] channel_irq_level = 3'h0;
  logic [15:0] chan_flag_set = 16'h0000;
  logic [15:0] service_done = 16'h0000;
  logic [3:0] view_chan = 4'h0;
  logic emu_ram_req = 1'b0;
  tcp_host_req_t host_req;
  tcp_host_rsp_t host_rsp, r;
  tcp_chan_view_t chan_view;
  logic emu_ram_grant, emulation_enable, engine_run, stopped_flag;
  logic [15:0] irq_req, first_timebase, second_timebase;
  int fails = 0;
  int cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  tcp_host_model host (.clk_sys(clk_sys), .host_req(host_req),
    .host_rsp(host_rsp));
  tcp_control DUT (.clk_sys(clk_sys), .rst(rst),
    .ext_timebase_pin(ext_timebase_pin), .host_req(host_req),
    .host_rsp(host_rsp), .channel_irq_level(channel_irq_level),
    .chan_flag_set(chan_flag_set), .service_done(service_done),
    .view_chan(view_chan), .chan_view(chan_view),
    .emu_ram_req(emu_ram_req), .emu_ram_grant(emu_ram_grant),
    .emulation_enable(emulation_enable), .engine_run(engine_run),
    .stopped_flag(stopped_flag), .irq_req(irq_req),
    .first_timebase(first_timebase), .second_timebase(second_timebase));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d,
      input logic [1:0] be = 2'h3);
    host.xfer(1'b0, a, be, d, r);
  endtask
  task automatic rd(input logic [8:0] a);
    host.xfer(1'b1, a, 2'h3, 16'h0000, r);
  endtask
  function automatic logic [15:0] cnt(input bit sec);
    return sec ? second_timebase : first_timebase;
  endfunction
  // First pass aligns to a step, second one measures; bounded against hangs
  task automatic period(input bit sec, output int n);
    logic [15:0] v;
    repeat (2) begin
      v = cnt(sec);
      n = 0;
      while (cnt(sec) === v && n < 600) begin
        @(negedge clk_sys);
        n++;
      end
    end
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic s_emu();
    @(posedge clk_sys);
    emu_ram_req <= 1'b1;
    cyc(1);
    check(emu_ram_grant, 1'b1);
    wr(OFS_MODULE_CONFIG, 16'h0400);
    wr(OFS_MODULE_CONFIG, 16'h0000);
    rd(OFS_MODULE_CONFIG);
    check(r.rdata, 16'h0400);
    check({emulation_enable, emu_ram_grant}, 2'h2);
  endtask
  task automatic s_tb1();
    int n;
    for (int p = 0; p < 2; p++) begin
      for (int d = 0; d < 4; d++) begin
        wr(OFS_MODULE_CONFIG, 16'((d << 13) | (p << 6)));
        period(1'b0, n);
        check(n, (p ? 4 : 32) << d);
      end
    end
  endtask
  task automatic s_tb2();
    int n;
    logic [15:0] v;
    @(posedge clk_sys);
    ext_timebase_pin <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      wr(OFS_MODULE_CONFIG, 16'(16'h0200 | (d << 11)));
      period(1'b1, n);
      check(n, 8 << d);
    end
    @(posedge clk_sys);
    ext_timebase_pin <= 1'b0;
    cyc(8);
    v = second_timebase;
    cyc(100);
    check(second_timebase, v);
    for (int d = 0; d < 2; d++) begin
      wr(OFS_MODULE_CONFIG, 16'(d << 11));
      cyc(8);
      v = second_timebase;
      repeat (4) begin
        @(posedge clk_sys);
        ext_timebase_pin <= 1'b1;
        cyc(10);
        @(posedge clk_sys);
        ext_timebase_pin <= 1'b0;
        cyc(10);
      end
      check(second_timebase - v, 4 >> d);
    end
  endtask
  task automatic s_stop();
    logic [31:0] v;
    wr(OFS_MODULE_CONFIG, 16'h8040);
    cyc(2);
    v = {first_timebase, second_timebase};
    check({engine_run, stopped_flag}, 2'h1);
    cyc(60);
    check({first_timebase, second_timebase}, v);
    rd(OFS_MODULE_CONFIG);
    check(r.rdata, 16'h8540);
    wr(OFS_MODULE_CONFIG, 16'h0040);
    cyc(30);
    check(first_timebase !== v[31:16], 1'b1);
  endtask
  task automatic s_irq();
    @(posedge clk_sys);
    channel_irq_level <= 3'h1;
    wr(OFS_IRQ_ENABLE, 16'h0002, 2'h1);
    check(r.err, 1'b1);
    wr(OFS_IRQ_ENABLE, 16'h0001);
    @(posedge clk_sys);
    chan_flag_set <= 16'h0003;
    @(posedge clk_sys);
    chan_flag_set <= 16'h0000;
    cyc(1);
    check(irq_req, 16'h0001);
    @(posedge clk_sys);
    channel_irq_level <= 3'h0;
    cyc(2);
    check(irq_req, 16'h0000);
    @(posedge clk_sys);
    channel_irq_level <= 3'h1;
    wr(OFS_IRQ_FLAG, 16'h0000);
    cyc(2);
    check(irq_req, 16'h0001);
    rd(OFS_IRQ_FLAG);
    check(r.rdata, 16'h0003);
    wr(OFS_IRQ_FLAG, 16'hFFFE);
    rd(OFS_IRQ_FLAG);
    check(r.rdata, 16'h0002);
    wr(OFS_IRQ_FLAG, 16'h0000, 2'h1);
    check(r.err, 1'b0);
    rd(OFS_IRQ_FLAG);
    check(r.rdata, 16'h0000);
    check(irq_req, 16'h0000);
  endtask
  task automatic fn(input logic [3:0] f, input logic [1:0] s,
      input logic [1:0] q, input tcp_action_t a, input tcp_mode_t m);
    wr(OFS_FUNC0, {12'h000, f});
    wr(OFS_SEQ0, {14'h0000, q});
    wr(OFS_SRV0, {14'h0000, s});
    cyc(2);
    check(chan_view, {f, q, s, a, m});
  endtask
  task automatic s_chan();
    int n;
    fn(FN_DISCRETE_IO, 2'h1, 2'h0, ACT_FORCE_HIGH, MODE_TRANS);
    fn(FN_DISCRETE_IO, 2'h2, 2'h1, ACT_FORCE_LOW, MODE_MATCH);
    fn(FN_DISCRETE_IO, 2'h3, 2'h2, ACT_UPDATE, MODE_ON_REQUEST);
    fn(FN_CAPTURE_COUNT, 2'h1, 2'h3, ACT_INIT, MODE_LINK_CONT);
    fn(FN_OUTPUT_COMPARE, 2'h1, 2'h1, ACT_HOST_PULSE, MODE_EXEC_ALL);
    fn(FN_OUTPUT_COMPARE, 2'h3, 2'h2, ACT_CONT_PULSE, MODE_TB_ONLY);
    fn(FN_PWM, 2'h1, 2'h0, ACT_IMMEDIATE, MODE_NONE);
    fn(FN_STEPPER, 2'h3, 2'h0, ACT_STEP, MODE_NONE);
    fn(FN_SYNCED_PWM, 2'h2, 2'h3, ACT_INIT, MODE_UNIMPL);
    fn(FN_EDGE_PERIOD, 2'h1, 2'h2, ACT_INIT, MODE_MISS_BANK);
    fn(FN_POSITION_PULSE, 2'h3, 2'h1, ACT_FORCE_CHANGE, MODE_BY_TIME);
    fn(FN_DISCRETE_IO, 2'h3, 2'h0, ACT_INIT, MODE_TRANS);
    fn(FN_STEPPER, 2'h1, 2'h0, ACT_NONE, MODE_NONE);
    fn(FN_SYNCED_PWM, 2'h3, 2'h1, ACT_IMMEDIATE, MODE_1);
    @(posedge clk_sys);
    service_done <= 16'h0001;
    @(posedge clk_sys);
    service_done <= 16'h0000;
    n = 0;
    do begin
      rd(OFS_SRV0);
      n++;
    end while (r.rdata[1:0] !== 2'h0 && n < 8);
    check(r.rdata, 16'h0000);
  endtask
  // Second reset: emulation bit may be fixed again, even to zero
  task automatic s_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    cyc(3);
    check(emulation_enable, 1'b0);
    @(posedge clk_sys);
    rst <= 1'b0;
    wr(OFS_MODULE_CONFIG, 16'h0000);
    wr(OFS_MODULE_CONFIG, 16'h0400);
    check(emulation_enable, 1'b0);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    s_emu();
    s_tb1();
    s_tb2();
    s_stop();
    s_irq();
    s_chan();
    s_reset();
    rd(9'h100);
    check({r.ack, r.err, r.rdata}, 18'h20000);
    test_done();
  end
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule
